// [common/dmaab_defs.svh]
`ifndef DMAAB_DEFS_SVH
`define DMAAB_DEFS_SVH

// Transfer information widths
`define DMAAB_ADDR_W 26
`define DMAAB_CNT_W 24
`define DMAAB_MSB_LO 24

// Priority slot indices and reset value of the rotating lowest slot
`define DMAAB_SLOT_CH0 2'h0
`define DMAAB_SLOT_CH1 2'h1
`define DMAAB_SLOT_EXT 2'h2
`define DMAAB_LOW_RESET 2'h2

// Transfer step in bytes
`define DMAAB_STEP_BYTE 24'h00_0001
`define DMAAB_STEP_WORD 24'h00_0002

`endif

// [common/dmaab_pkg.sv]
package dmaab_pkg;

  typedef enum logic [1:0] {ARB_IDLE, ARB_HOLD_WAIT, ARB_GRANT} dmaab_arb_t;

  typedef enum logic [1:0] {OWN_CH0, OWN_CH1, OWN_EXT, OWN_REF} dmaab_owner_t;

  typedef enum logic [1:0] {FLD_REQ, FLD_TGT, FLD_CNT, FLD_TGT_MSB} dmaab_field_t;

  typedef enum logic [1:0] {PRIO_FIXED, PRIO_LOWSEL, PRIO_ROTATE, PRIO_RSVD} dmaab_prio_t;

endpackage : dmaab_pkg

// [rtl/dmaab_arbiter.sv]
`timescale 1ns/1ps
`include "dmaab_defs.svh"

// What this block does
// - Arbitrate two channels, external master, refresh
// - Hold request to core before any acknowledge
// - Refresh status active during valid refresh
// - Refresh request always wins arbitration
// - Reset order: channel 0, channel 1, external
// - Low-priority selection puts chosen request last
// - Rotation moves granted request to lowest
// - Expired byte count ends buffer, drives end-of-process
// - End-of-process input terminates buffer early
// - Synchronous sampling at end of transfer
// - Asynchronous: sample state start, act state end
// - Dropped request ends transfer when sampled inactive
// - Single mode: transfer once, then idle
// - Autoinitialize reloads original transfer information
// - Chaining writes go to base registers
// - Chain without new information goes idle
// - Chaining entry raises irq; MSB write clears
// - Chained reload raises irq again
// - Clearing chain control exits, withdraws irq
// - Mask bit suspends chaining without exiting
// - Base target MSB needs expanded I/O space
module dmaab_arbiter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Channel request pins and acknowledges
  input wire logic [1:0] chanRequest,
  output logic [1:0] chanAcknowledge_n,
  // External bus master
  input wire logic extMasterRequest,
  output logic extMasterGrant,
  // Refresh unit
  input wire logic refreshRequest,
  input wire logic refreshCycleValid,
  output logic refreshStatus_n,
  // Core hold handshake
  output logic coreHoldRequest,
  input wire logic coreHoldAck,
  // End-of-process open-drain pin
  input wire logic endOfProcessIn_n,
  output logic endOfProcessOut_n,
  output logic endOfProcessOe,
  // Bus unit progress for the granted channel
  input wire logic stateEnd,
  input wire logic requesterAccess,
  input wire logic xferEnd,
  input wire logic xferWord,
  // Command register two and mask
  input wire logic eopSyncMode,
  input wire logic reqSyncMode,
  input wire dmaab_pkg::dmaab_prio_t prioMode,
  input wire logic [1:0] lowPrioSel,
  input wire logic [1:0] maskBit,
  input wire logic [1:0] autoInit,
  input wire logic [1:0] chainEnable,
  input wire logic expandedIoEnable,
  // Transfer information writes
  input wire logic progWrite,
  input wire logic progChan,
  input wire dmaab_pkg::dmaab_field_t progField,
  input wire logic [`DMAAB_ADDR_W-1:0] progData,
  // Status
  output logic [1:0] chainIrq,
  output logic [1:0] chanReady,
  output logic [1:0] chainOn,
  output logic [`DMAAB_ADDR_W-1:0] curReqAddr,
  output logic [`DMAAB_ADDR_W-1:0] curTgtAddr
);

  // ==========================================================
  // Pin synchronisers
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic [1:0] chanReqS;
  logic extReqS;
  logic eopActS;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
    end else begin
      syncA <= {~endOfProcessIn_n, extMasterRequest, chanRequest};
      syncB <= syncA;
    end
  end

  assign chanReqS = syncB[1:0];
  assign extReqS = syncB[2];
  assign eopActS = syncB[3];

  // ==========================================================
  // Priority helpers
  function automatic logic [1:0] nextSlot(input logic [1:0] s);
    nextSlot = (s >= `DMAAB_SLOT_EXT) ? `DMAAB_SLOT_CH0 : 2'(s + 2'h1);
  endfunction : nextSlot

  // Returns {found, slot}; slots above the lowest are taken circularly
  function automatic logic [2:0] pickWinner(input logic [2:0] reqs, input logic [1:0] low);
    logic [1:0] first;
    logic [1:0] second;
    logic [1:0] last;
    first = nextSlot(low);
    second = nextSlot(first);
    last = nextSlot(second);
    if (reqs[first]) pickWinner = {1'b1, first};
    else if (reqs[second]) pickWinner = {1'b1, second};
    else if (reqs[last]) pickWinner = {1'b1, last};
    else pickWinner = 3'h0;
  endfunction : pickWinner

  // ==========================================================
  // Arbitration
  dmaab_pkg::dmaab_arb_t arbState;
  dmaab_pkg::dmaab_owner_t owner;
  logic [1:0] rotLow;
  logic [1:0] lowSlot;
  logic [2:0] reqVec;
  logic [2:0] winner;
  logic anyReq;
  logic ownerRelease;
  logic [1:0] ownCh;
  logic [1:0] chanStop;

  // Masked or unarmed channels never contend
  assign reqVec = {extReqS, chanReqS & chanReady & ~maskBit};
  assign anyReq = refreshRequest | (|reqVec);

  always_comb begin
    unique case (prioMode)
      dmaab_pkg::PRIO_LOWSEL: lowSlot = (lowPrioSel > `DMAAB_SLOT_EXT) ?
                                        `DMAAB_SLOT_EXT : lowPrioSel;
      dmaab_pkg::PRIO_ROTATE: lowSlot = rotLow;
      default: lowSlot = `DMAAB_LOW_RESET;
    endcase
  end

  assign winner = pickWinner(reqVec, lowSlot);

  always_comb begin
    unique case (owner)
      dmaab_pkg::OWN_CH0: ownerRelease = chanStop[0];
      dmaab_pkg::OWN_CH1: ownerRelease = chanStop[1];
      dmaab_pkg::OWN_EXT: ownerRelease = !extReqS;
      dmaab_pkg::OWN_REF: ownerRelease = !refreshRequest;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arbState <= dmaab_pkg::ARB_IDLE;
      owner <= dmaab_pkg::OWN_REF;
    end else begin
      unique case (arbState)
        dmaab_pkg::ARB_IDLE: if (anyReq) arbState <= dmaab_pkg::ARB_HOLD_WAIT;
        dmaab_pkg::ARB_HOLD_WAIT: begin
          // Winner chosen only once the core has let go of the bus
          if (!anyReq) begin
            arbState <= dmaab_pkg::ARB_IDLE;
          end else if (coreHoldAck) begin
            arbState <= dmaab_pkg::ARB_GRANT;
            if (refreshRequest) owner <= dmaab_pkg::OWN_REF;
            else owner <= dmaab_pkg::dmaab_owner_t'(winner[1:0]);
          end
        end
        dmaab_pkg::ARB_GRANT: if (ownerRelease) arbState <= dmaab_pkg::ARB_IDLE;
        default: arbState <= dmaab_pkg::ARB_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rotLow <= `DMAAB_LOW_RESET;
    end else if (arbState == dmaab_pkg::ARB_HOLD_WAIT && coreHoldAck && !refreshRequest
                 && winner[2]) begin
      rotLow <= winner[1:0];
    end
  end

  assign coreHoldRequest = (arbState != dmaab_pkg::ARB_IDLE);
  assign ownCh[0] = (arbState == dmaab_pkg::ARB_GRANT) && (owner == dmaab_pkg::OWN_CH0);
  assign ownCh[1] = (arbState == dmaab_pkg::ARB_GRANT) && (owner == dmaab_pkg::OWN_CH1);
  assign chanAcknowledge_n = ~ownCh;
  assign extMasterGrant = (arbState == dmaab_pkg::ARB_GRANT) && (owner == dmaab_pkg::OWN_EXT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) refreshStatus_n <= 1'b1;
    else refreshStatus_n <= !((arbState == dmaab_pkg::ARB_GRANT) &&
                              (owner == dmaab_pkg::OWN_REF) && refreshCycleValid);
  end

  // ==========================================================
  // Termination sampling
  logic eopAct;
  logic reqAct;
  logic eopAsync;
  logic [1:0] reqAsync;
  logic eopSeen;
  logic [1:0] reqSeen;
  logic [`DMAAB_CNT_W-1:0] step;
  logic [1:0] expire;
  logic [1:0] bufEnd;
  logic [1:0] reloadEv;

  // Async sample taken at each state start, used at that state's end
  // Tracks the pins outside a grant so no sample from an older grant survives
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eopAsync <= 1'b0;
      reqAsync <= 2'h0;
    end else if (stateEnd || arbState != dmaab_pkg::ARB_GRANT) begin
      eopAsync <= eopActS;
      reqAsync <= chanReqS;
    end
  end

  assign eopAct = eopSyncMode ? xferEnd : (stateEnd && requesterAccess);
  assign reqAct = reqSyncMode ? xferEnd : (stateEnd && requesterAccess);
  assign eopSeen = eopSyncMode ? eopActS : eopAsync;
  assign reqSeen = reqSyncMode ? chanReqS : reqAsync;
  assign step = xferWord ? `DMAAB_STEP_WORD : `DMAAB_STEP_BYTE;

  logic [`DMAAB_ADDR_W-1:0] baseReq [2];
  logic [`DMAAB_ADDR_W-1:0] baseTgt [2];
  logic [`DMAAB_CNT_W-1:0] baseCnt [2];
  logic [`DMAAB_ADDR_W-1:0] curReq [2];
  logic [`DMAAB_ADDR_W-1:0] curTgt [2];
  logic [`DMAAB_CNT_W-1:0] curCnt [2];
  logic [1:0] baseValid;
  logic [1:0] chainEnPrev;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      expire[i] = ownCh[i] && xferEnd && (curCnt[i] <= step);
      bufEnd[i] = expire[i] || (ownCh[i] && eopAct && eopSeen);
      chanStop[i] = bufEnd[i] || (ownCh[i] && reqAct && !reqSeen[i]);
      reloadEv[i] = bufEnd[i] && (chainOn[i] ? baseValid[i] : autoInit[i]);
    end
  end

  // Own drive ends one cycle later; pin stays released otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) endOfProcessOe <= 1'b0;
    else endOfProcessOe <= |expire;
  end

  assign endOfProcessOut_n = 1'b0;

  // ==========================================================
  // Transfer information registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        baseReq[i] <= '0;
        baseTgt[i] <= '0;
        baseCnt[i] <= '0;
        curReq[i] <= '0;
        curTgt[i] <= '0;
        curCnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reloadEv[i]) begin
          curReq[i] <= baseReq[i];
          curTgt[i] <= baseTgt[i];
          curCnt[i] <= baseCnt[i];
        end else if (ownCh[i] && xferEnd) begin
          curReq[i] <= curReq[i] + `DMAAB_ADDR_W'(step);
          curTgt[i] <= curTgt[i] + `DMAAB_ADDR_W'(step);
          curCnt[i] <= curCnt[i] - step;
        end
        // Chaining writes touch only the base set; the running buffer is left alone
        if (progWrite && progChan == i[0]) begin
          unique case (progField)
            dmaab_pkg::FLD_REQ: begin
              baseReq[i] <= progData;
              if (!chainOn[i]) curReq[i] <= progData;
            end
            dmaab_pkg::FLD_TGT: begin
              baseTgt[i][`DMAAB_MSB_LO-1:0] <= progData[`DMAAB_MSB_LO-1:0];
              if (!chainOn[i]) curTgt[i][`DMAAB_MSB_LO-1:0] <= progData[`DMAAB_MSB_LO-1:0];
            end
            dmaab_pkg::FLD_CNT: begin
              baseCnt[i] <= progData[`DMAAB_CNT_W-1:0];
              if (!chainOn[i]) curCnt[i] <= progData[`DMAAB_CNT_W-1:0];
            end
            dmaab_pkg::FLD_TGT_MSB: if (expandedIoEnable) begin
              baseTgt[i][`DMAAB_ADDR_W-1:`DMAAB_MSB_LO] <=
                progData[`DMAAB_ADDR_W-`DMAAB_MSB_LO-1:0];
              if (!chainOn[i]) curTgt[i][`DMAAB_ADDR_W-1:`DMAAB_MSB_LO] <=
                progData[`DMAAB_ADDR_W-`DMAAB_MSB_LO-1:0];
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Channel readiness and chaining state
  logic [1:0] msbWrite;
  logic [1:0] cntWrite;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      msbWrite[i] = progWrite && (progChan == i[0]) &&
                    (progField == dmaab_pkg::FLD_TGT_MSB) && expandedIoEnable;
      cntWrite[i] = progWrite && (progChan == i[0]) && (progField == dmaab_pkg::FLD_CNT);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanReady <= 2'h0;
      chainOn <= 2'h0;
      chainEnPrev <= 2'h0;
      baseValid <= 2'h0;
      chainIrq <= 2'h0;
    end else begin
      chainEnPrev <= chainEnable;
      for (int i = 0; i < 2; i++) begin
        // Counting a new buffer arms the channel outside chaining
        if (cntWrite[i] && !chainOn[i]) chanReady[i] <= 1'b1;
        if (bufEnd[i] && !reloadEv[i]) chanReady[i] <= 1'b0;
        if (msbWrite[i]) begin
          chainIrq[i] <= 1'b0;
          if (chainOn[i]) baseValid[i] <= 1'b1;
        end
        if (bufEnd[i] && chainOn[i]) begin
          if (baseValid[i]) begin
            baseValid[i] <= 1'b0;
            chainIrq[i] <= 1'b1;
          end else begin
            chainOn[i] <= 1'b0;
          end
        end
        if (chainEnable[i] && !chainEnPrev[i]) begin
          // Base set counts as empty on entry, so ask for it at once
          chainOn[i] <= 1'b1;
          baseValid[i] <= 1'b0;
          chainIrq[i] <= 1'b1;
        end
        if (!chainEnable[i]) begin
          chainOn[i] <= 1'b0;
          chainIrq[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      curReqAddr <= '0;
      curTgtAddr <= '0;
    end else begin
      curReqAddr <= ownCh[1] ? curReq[1] : curReq[0];
      curTgtAddr <= ownCh[1] ? curTgt[1] : curTgt[0];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence holdGranted_s;
    arbState == dmaab_pkg::ARB_HOLD_WAIT && coreHoldAck;
  endsequence

  sequence chanWins0_s;
    holdGranted_s ##0 (!refreshRequest && reqVec[0] && prioMode == dmaab_pkg::PRIO_FIXED);
  endsequence

  hold_before_ack_a: assert property ($fell(chanAcknowledge_n[0]) |->
    $past(coreHoldAck) && coreHoldRequest) else $error("Acknowledge without core hold");
  refresh_status_a: assert property (arbState == dmaab_pkg::ARB_GRANT &&
    owner == dmaab_pkg::OWN_REF && refreshCycleValid |=> !refreshStatus_n)
    else $error("Refresh status not active");
  refresh_wins_a: assert property (holdGranted_s ##0 refreshRequest |=>
    owner == dmaab_pkg::OWN_REF) else $error("Refresh lost arbitration");
  default_order_a: assert property (chanWins0_s |=> !chanAcknowledge_n[0])
    else $error("Channel 0 not first in default order");
  rotate_lowest_a: assert property (holdGranted_s ##0 (!refreshRequest && winner[2] &&
    prioMode == dmaab_pkg::PRIO_ROTATE) |=> lowSlot == $past(winner[1:0]))
    else $error("Granted request not moved to lowest");
  expire_eop_a: assert property (|expire |=> endOfProcessOe ##1 !endOfProcessOe)
    else $error("End-of-process pulse wrong");
  single_idle_a: assert property (bufEnd[0] && !chainOn[0] && !autoInit[0] |=>
    !chanReady[0]) else $error("Single mode channel not idle");
  chain_entry_a: assert property ($rose(chainOn[0]) |-> chainIrq[0] && !baseValid[0])
    else $error("Chaining entry without irq");
  chain_exit_a: assert property (!chainEnable[0] |=> !chainIrq[0] && !chainOn[0])
    else $error("Chaining exit left irq");
  msb_gate_a: assert property (progWrite && progField == dmaab_pkg::FLD_TGT_MSB &&
    !expandedIoEnable |=> $stable(baseTgt[0]) && $stable(baseTgt[1]))
    else $error("MSB written outside expanded space");

endmodule : dmaab_arbiter

// [sim/dmaab_core_model.sv]
`timescale 1ns/1ps

// ==========
// Core and bus unit seen from the arbiter
module dmaab_core_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Answer delay of the core, 0 = prompt
  input wire logic [1:0] holdLat,
  // Arbiter side
  input wire logic coreHoldRequest,
  input wire logic chanBusy,
  output logic coreHoldAck,
  output logic stateEnd,
  output logic xferEnd,
  output logic requesterAccess
);
  logic [1:0] waitCnt;
  logic phase;

  // Ack only after hold, dropped with it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 2'h0;
      coreHoldAck <= 1'b0;
    end else if (!coreHoldRequest) begin
      waitCnt <= 2'h0;
      coreHoldAck <= 1'b0;
    end else if (waitCnt >= holdLat) begin
      coreHoldAck <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 2'h1;
    end
  end

  // Two-state data transfers, every state a requester access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      stateEnd <= 1'b0;
      xferEnd <= 1'b0;
    end else begin
      phase <= chanBusy & ~phase;
      stateEnd <= chanBusy;
      xferEnd <= chanBusy & phase;
    end
  end

  assign requesterAccess = chanBusy;
endmodule : dmaab_core_model

// [sim/tb_dmaab_arbiter.sv]
`timescale 1ns/1ps
`include "dmaab_defs.svh"

module tb_dmaab_arbiter;
  // ==========
  // Signals
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] chanRequest = 2'h0, maskBit = 2'h0, autoInit = 2'h0, chainEnable = 2'h0;
  logic [1:0] lowPrioSel = 2'h0, holdLat = 2'h1, chanAcknowledge_n, chainIrq, chanReady, chainOn;
  logic extMasterRequest = 1'b0, refreshRequest = 1'b0, refreshCycleValid = 1'b0;
  logic endOfProcessIn_n = 1'b1, xferWord = 1'b0, eopSyncMode = 1'b0, reqSyncMode = 1'b0;
  logic expandedIoEnable = 1'b0, progWrite = 1'b0, progChan = 1'b0;
  logic extMasterGrant, refreshStatus_n, coreHoldRequest, coreHoldAck, endOfProcessOut_n;
  logic endOfProcessOe, stateEnd, requesterAccess, xferEnd;
  dmaab_pkg::dmaab_prio_t prioMode = dmaab_pkg::PRIO_FIXED;
  dmaab_pkg::dmaab_field_t progField = dmaab_pkg::FLD_REQ;
  logic [`DMAAB_ADDR_W-1:0] progData = '0, curReqAddr, curTgtAddr, a, b;
  logic [31:0] seed = 32'h0000_31A5, v;
  logic [1:0] lastWin = 2'h2;
  int fail_count = 0, checks = 0, who;

  always #10 sys_clk = ~sys_clk;

  dmaab_arbiter i_dmaab_arbiter (.sys_clk, .rst_n, .chanRequest, .chanAcknowledge_n,
    .extMasterRequest, .extMasterGrant, .refreshRequest, .refreshCycleValid, .refreshStatus_n,
    .coreHoldRequest, .coreHoldAck, .endOfProcessIn_n, .endOfProcessOut_n, .endOfProcessOe,
    .stateEnd, .requesterAccess, .xferEnd, .xferWord, .eopSyncMode, .reqSyncMode, .prioMode,
    .lowPrioSel, .maskBit, .autoInit, .chainEnable, .expandedIoEnable, .progWrite, .progChan,
    .progField, .progData, .chainIrq, .chanReady, .chainOn, .curReqAddr, .curTgtAddr);

  dmaab_core_model i_dmaab_core_model (.sys_clk, .rst_n, .holdLat, .coreHoldRequest,
    .chanBusy(~&chanAcknowledge_n), .coreHoldAck, .stateEnd, .xferEnd, .requesterAccess);

  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Winner: refresh first, then circular order above the lowest slot
  function automatic int expWin(logic [3:0] r, logic [1:0] low);
    int s;
    if (r[3]) return 3;
    for (int k = 1; k <= 3; k++) begin
      s = (int'(low) + k) % 3;
      if (r[s]) return s;
    end
    return 7;
  endfunction : expWin

  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(bit ok, string msg);
    checks++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic need(bit ok, string msg);
    chk(ok, msg);
    if (!ok) report_and_stop();
  endtask : need

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Second edge keeps progWrite from being driven twice in one step
  task automatic prog(bit ch, dmaab_pkg::dmaab_field_t f, logic [`DMAAB_ADDR_W-1:0] d);
    progWrite <= 1'b1;
    progChan <= ch;
    progField <= f;
    progData <= d;
    tick(1);
    progWrite <= 1'b0;
    tick(1);
  endtask : prog

  task automatic arm(bit ch, logic [23:0] cnt, logic [`DMAAB_ADDR_W-1:0] ad);
    prog(ch, dmaab_pkg::FLD_REQ, ad);
    prog(ch, dmaab_pkg::FLD_TGT, ~ad);
    prog(ch, dmaab_pkg::FLD_CNT, {2'b00, cnt});
  endtask : arm

  // Outputs are read at the edge, i.e. last cycle's settled values
  task automatic waitOwner();
    who = 7;
    for (int i = 0; i < 40 && who == 7; i++) begin
      tick(1);
      if (chanAcknowledge_n === 2'b10) who = 0;
      else if (chanAcknowledge_n === 2'b01) who = 1;
      else if (extMasterGrant === 1'b1) who = 2;
      else if (refreshStatus_n === 1'b0) who = 3;
    end
    need(who != 7, "no bus owner");
    chk(coreHoldAck === 1'b1 && coreHoldRequest === 1'b1, "grant without core hold");
  endtask : waitOwner

  // Idle must hold six cycles so a late grant is not missed
  task automatic waitIdle();
    int run;
    run = 0;
    for (int i = 0; i < 100 && run < 6; i++) begin
      tick(1);
      if (chanAcknowledge_n === 2'b11 && extMasterGrant === 1'b0 &&
          refreshStatus_n === 1'b1 && coreHoldRequest === 1'b0) run++;
      else run = 0;
    end
    need(run == 6, "bus not released");
  endtask : waitIdle

  task automatic contest(logic [3:0] r);
    int exp;
    exp = expWin(r, prioMode == dmaab_pkg::PRIO_LOWSEL ? (lowPrioSel == 2'h3 ? 2'h2 : lowPrioSel)
                  : prioMode == dmaab_pkg::PRIO_ROTATE ? lastWin : 2'h2);
    arm(0, 24'h00_0100, `DMAAB_ADDR_W'(rnd()));
    arm(1, 24'h00_0100, `DMAAB_ADDR_W'(rnd()));
    {refreshRequest, extMasterRequest, chanRequest} <= r;
    refreshCycleValid <= r[3];
    waitOwner();
    chk(who == exp, "wrong bus owner");
    if (who < 3) lastWin = who[1:0];
    // Pin requests go first so refresh release leaves no stale winner
    {extMasterRequest, chanRequest} <= 3'h0;
    tick(3);
    refreshRequest <= 1'b0;
    refreshCycleValid <= 1'b0;
    waitIdle();
  endtask : contest

  task automatic xfer0();
    bit seen;
    seen = 0;
    maskBit <= 2'b00;
    chanRequest[0] <= 1'b1;
    for (int i = 0; i < 200 && !seen; i++) begin
      tick(1);
      seen = (endOfProcessOe === 1'b1);
    end
    chanRequest[0] <= 1'b0;
    maskBit <= 2'b01;
    need(seen, "no end of process");
    tick(1);
    chk(endOfProcessOe === 1'b0 && endOfProcessOut_n === 1'b0, "bad end of process");
    waitIdle();
  endtask : xfer0

  // ==========
  // Main sequence
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(3);
    chk(chanAcknowledge_n === 2'b11 && extMasterGrant === 1'b0 && chainIrq === 2'b00 &&
        chanReady === 2'b00 && chainOn === 2'b00 && endOfProcessOe === 1'b0, "reset");
    contest(4'hF);
    contest(4'h7);
    contest(4'h6);
    prioMode <= dmaab_pkg::PRIO_ROTATE;
    tick(1);
    contest(4'h3);
    repeat (30) begin
      v = rnd();
      prioMode <= dmaab_pkg::dmaab_prio_t'(v[1:0]);
      lowPrioSel <= v[3:2];
      {eopSyncMode, reqSyncMode} <= v[5:4];
      holdLat <= v[7:6];
      tick(1);
      contest(v[11:8] == 4'h0 ? 4'h1 : v[11:8]);
    end
    prioMode <= dmaab_pkg::PRIO_FIXED;
    for (int s = 0; s < 2; s++) begin
      eopSyncMode <= s[0];
      arm(0, 24'h00_0100, `DMAAB_ADDR_W'(rnd()));
      chanRequest[0] <= 1'b1;
      waitOwner();
      endOfProcessIn_n <= 1'b0;
      tick(4);
      endOfProcessIn_n <= 1'b1;
      waitIdle();
      chk(chanReady[0] === 1'b0, "channel armed after abort");
      chanRequest[0] <= 1'b0;
    end
    for (int k = 1; k <= 4; k++) begin
      v = rnd();
      xferWord <= v[0];
      arm(0, 24'(k), `DMAAB_ADDR_W'(v));
      xfer0();
      chk(chanReady[0] === 1'b0, "channel armed after single buffer");
    end
    maskBit <= 2'b00;
    chanRequest[0] <= 1'b1;
    tick(12);
    chk(chanAcknowledge_n[0] === 1'b1 && coreHoldRequest === 1'b0, "idle channel granted");
    chanRequest[0] <= 1'b0;
    autoInit[0] <= 1'b1;
    a = `DMAAB_ADDR_W'(rnd());
    arm(0, 24'h00_0001, a);
    xfer0();
    chk(chanReady[0] === 1'b1 && curReqAddr === a, "no reload");
    chk(curTgtAddr === {2'b00, ~a[23:0]}, "target not reloaded");
    autoInit[0] <= 1'b0;
    a = `DMAAB_ADDR_W'(rnd());
    arm(0, 24'h00_0001, a);
    chainEnable[0] <= 1'b1;
    tick(3);
    chk(chainIrq[0] === 1'b1 && chainOn[0] === 1'b1, "chain entry");
    b = `DMAAB_ADDR_W'(rnd());
    arm(0, 24'h00_0001, b);
    prog(0, dmaab_pkg::FLD_TGT_MSB, ~b);
    chk(chainIrq[0] === 1'b1 && curReqAddr === a, "base write leaked");
    expandedIoEnable <= 1'b1;
    prog(0, dmaab_pkg::FLD_TGT_MSB, ~b);
    tick(1);
    chk(chainIrq[0] === 1'b0, "irq kept after msb write");
    xfer0();
    chk(chainIrq[0] === 1'b1 && curReqAddr === b && chainOn[0] === 1'b1, "chain reload");
    chk(curTgtAddr === {~b[1:0], ~b[23:0]}, "chained target not loaded");
    chanRequest[0] <= 1'b1;
    tick(12);
    chk(chanAcknowledge_n[0] === 1'b1 && chainOn[0] === 1'b1, "mask ignored");
    xfer0();
    chk(chainOn[0] === 1'b0 && chanReady[0] === 1'b0, "chain without base");
    chainEnable[0] <= 1'b0;
    arm(0, 24'h00_0001, a);
    chainEnable[0] <= 1'b1;
    tick(3);
    chk(chainIrq[0] === 1'b1 && chainOn[0] === 1'b1, "chain re-entry");
    chainEnable[0] <= 1'b0;
    tick(2);
    chk(chainIrq[0] === 1'b0 && chainOn[0] === 1'b0, "chain exit");
    report_and_stop();
  end
endmodule : tb_dmaab_arbiter
